//--- verilog/tlvi_irq_unit.v
`timescale 1ns/100ps
`include "tlvi_consts.vh"

module tlvi_irq_unit #(
    parameter NSRC = `TLVI_NSRC,
    parameter IW = `TLVI_IDX_W
) (
    input wire SYS_CLK_I,
    input wire RESETN_I,
    input wire [7:0] SFR_ADDR_I,
    input wire SFR_WR_I,
    input wire [7:0] SFR_WDATA_I,
    input wire SFR_RD_I,
    output reg [7:0] SFR_RDATA_O,
    input wire [NSRC-1:0] SRC_PEND_I,
    input wire INSTR_END_I,
    input wire IRQ_RETURN_INSTR_END_I,
    output reg CALL_O,
    output reg [15:0] CALL_VEC_O,
    output reg [NSRC-1:0] SRC_ACK_O,
    output reg ACT_LO_O,
    output reg ACT_HI_O
);

    localparam ST_IDLE = 1'b0;
    localparam ST_CALL = 1'b1;
    localparam [`TLVI_CNT_W-1:0] CALL_LAST = `TLVI_CALL_CLK - 1;
    localparam [7:0] RST_LEVEL = `TLVI_RST_IP;

    // enable and level registers
    reg [7:0] interrupt_enable;
    reg [5:0] base_level_reg;
    reg [7:0] ext_enable_reg_a;
    reg [7:0] ext_enable_reg_b;
    reg [7:0] ext_level_reg_a;
    reg [7:0] ext_level_reg_b;

    // service tracking
    reg act_lo;
    reg act_hi;
    reg holdoff;
    reg state;
    reg [`TLVI_CNT_W-1:0] cnt;

    // detect stage
    reg win_valid_q;
    reg win_hi_q;
    reg [IW-1:0] win_idx_q;

    wire global_irq_gate;
    wire [NSRC-1:0] en_bits;
    wire [NSRC-1:0] lvl_bits;
    wire [NSRC-1:0] req;
    wire [NSRC-1:0] eligible;
    wire win_valid;
    wire win_hi;
    wire [IW-1:0] win_idx;
    wire take;
    wire [15:0] next_vec;
    reg [7:0] next_rdata;

    assign global_irq_gate = interrupt_enable[`TLVI_GATE_BIT];

    // order 0..5 in base regs, 6..13 in reg a, 14..21 in reg b
    assign en_bits = {ext_enable_reg_b, ext_enable_reg_a,
                      interrupt_enable[`TLVI_BASE_SRC_W-1:0]};
    assign lvl_bits = {ext_level_reg_b, ext_level_reg_a, base_level_reg};

    genvar g;
    generate
        for (g = 0; g < NSRC; g = g + 1) begin : g_src
            // pending counts regardless of enable, gating happens here
            assign req[g] = SRC_PEND_I[g] & en_bits[g] & global_irq_gate;
            // high may preempt low, nothing preempts high
            assign eligible[g] = req[g] & ~act_hi
                                 & (lvl_bits[g] | ~act_lo);
        end
    endgenerate

    tlvi_arb #(
        .N(NSRC),
        .IW(IW)
    ) u_arb (
        .req_i(eligible),
        .lvl_i(lvl_bits),
        .valid_o(win_valid),
        .hi_o(win_hi),
        .idx_o(win_idx)
    );

    // one clock of detection ahead of the call
    always @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            win_valid_q <= 1'b0;
            win_hi_q <= 1'b0;
            win_idx_q <= {IW{1'b0}};
        end else begin
            win_valid_q <= win_valid;
            win_hi_q <= win_hi;
            win_idx_q <= win_idx;
        end
    end

    // a call starts only at an ordinary instruction end, never at a return end
    assign take = (state == ST_IDLE) && win_valid_q && INSTR_END_I
                  && !IRQ_RETURN_INSTR_END_I;

    // vector = base + 8 * order
    assign next_vec = `TLVI_VEC_BASE
                      + {{(16 - IW - `TLVI_VEC_SHIFT){1'b0}}, win_idx_q,
                         {`TLVI_VEC_SHIFT{1'b0}}};

    // register writes
    always @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            interrupt_enable <= `TLVI_RST_IE;
            base_level_reg <= RST_LEVEL[5:0];
            ext_enable_reg_a <= `TLVI_RST_EXT;
            ext_enable_reg_b <= `TLVI_RST_EXT;
            ext_level_reg_a <= `TLVI_RST_EXT;
            ext_level_reg_b <= `TLVI_RST_EXT;
        end else if (SFR_WR_I) begin
            if (SFR_ADDR_I == `TLVI_ADDR_IE) begin
                interrupt_enable <= SFR_WDATA_I;
            end else if (SFR_ADDR_I == `TLVI_ADDR_IP) begin
                base_level_reg <= SFR_WDATA_I[5:0];
            end else if (SFR_ADDR_I == `TLVI_ADDR_EIE_A) begin
                ext_enable_reg_a <= SFR_WDATA_I;
            end else if (SFR_ADDR_I == `TLVI_ADDR_EIE_B) begin
                ext_enable_reg_b <= SFR_WDATA_I;
            end else if (SFR_ADDR_I == `TLVI_ADDR_EIP_A) begin
                ext_level_reg_a <= SFR_WDATA_I;
            end else if (SFR_ADDR_I == `TLVI_ADDR_EIP_B) begin
                ext_level_reg_b <= SFR_WDATA_I;
            end
        end
    end

    // read mux, answered one clock after the strobe
    always @* begin
        next_rdata = 8'h00;
        if (SFR_ADDR_I == `TLVI_ADDR_IE) begin
            next_rdata = interrupt_enable;
        end else if (SFR_ADDR_I == `TLVI_ADDR_IP) begin
            // top two bits are unused and read as one
            next_rdata = {`TLVI_IP_RSVD, base_level_reg};
        end else if (SFR_ADDR_I == `TLVI_ADDR_EIE_A) begin
            next_rdata = ext_enable_reg_a;
        end else if (SFR_ADDR_I == `TLVI_ADDR_EIE_B) begin
            next_rdata = ext_enable_reg_b;
        end else if (SFR_ADDR_I == `TLVI_ADDR_EIP_A) begin
            next_rdata = ext_level_reg_a;
        end else if (SFR_ADDR_I == `TLVI_ADDR_EIP_B) begin
            next_rdata = ext_level_reg_b;
        end else if (SFR_ADDR_I == `TLVI_ADDR_STAT) begin
            next_rdata[`TLVI_STAT_ACT_LO] = act_lo;
            next_rdata[`TLVI_STAT_ACT_HI] = act_hi;
            next_rdata[`TLVI_STAT_HOLD] = holdoff;
            next_rdata[`TLVI_STAT_CALL] = state;
        end else if (SFR_ADDR_I == `TLVI_ADDR_WIN) begin
            next_rdata[`TLVI_WIN_VALID] = win_valid_q;
            next_rdata[`TLVI_WIN_HI] = win_hi_q;
            next_rdata[IW-1:0] = win_idx_q;
        end else if (SFR_ADDR_I == `TLVI_ADDR_REQ0) begin
            next_rdata = req[7:0];
        end else if (SFR_ADDR_I == `TLVI_ADDR_REQ1) begin
            next_rdata = req[15:8];
        end else if (SFR_ADDR_I == `TLVI_ADDR_REQ2) begin
            next_rdata[NSRC-17:0] = req[NSRC-1:16];
        end
    end

    always @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            SFR_RDATA_O <= 8'h00;
        end else if (SFR_RD_I) begin
            SFR_RDATA_O <= next_rdata;
        end
    end

    // marks the window between a return and the next instruction end
    always @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            holdoff <= 1'b0;
        end else if (IRQ_RETURN_INSTR_END_I) begin
            holdoff <= 1'b1;
        end else if (INSTR_END_I) begin
            holdoff <= 1'b0;
        end
    end

    // active service levels
    always @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            act_lo <= 1'b0;
            act_hi <= 1'b0;
        end else if (take) begin
            if (win_hi_q) begin
                act_hi <= 1'b1;
            end else begin
                act_lo <= 1'b1;
            end
        end else if (IRQ_RETURN_INSTR_END_I) begin
            // a return closes the innermost, i.e. highest, level
            if (act_hi) begin
                act_hi <= 1'b0;
            end else begin
                act_lo <= 1'b0;
            end
        end
    end

    // long call sequencer
    always @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state <= ST_IDLE;
            cnt <= {`TLVI_CNT_W{1'b0}};
            CALL_O <= 1'b0;
            CALL_VEC_O <= 16'h0000;
            SRC_ACK_O <= {NSRC{1'b0}};
        end else begin
            SRC_ACK_O <= {NSRC{1'b0}};
            case (state)
                ST_IDLE: begin
                    cnt <= {`TLVI_CNT_W{1'b0}};
                    if (take) begin
                        state <= ST_CALL;
                        CALL_O <= 1'b1;
                        CALL_VEC_O <= next_vec;
                        // lets auto-clearing sources drop their flag
                        SRC_ACK_O[win_idx_q] <= 1'b1;
                    end
                end
                ST_CALL: begin
                    if (cnt == CALL_LAST) begin
                        state <= ST_IDLE;
                        CALL_O <= 1'b0;
                        cnt <= {`TLVI_CNT_W{1'b0}};
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    CALL_O <= 1'b0;
                end
            endcase
        end
    end

    // level outputs for the core
    always @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ACT_LO_O <= 1'b0;
            ACT_HI_O <= 1'b0;
        end else begin
            ACT_LO_O <= act_lo;
            ACT_HI_O <= act_hi;
        end
    end

endmodule // tlvi_irq_unit

//--- verilog/tlvi_consts.vh
`ifndef TLVI_CONSTS_VH
`define TLVI_CONSTS_VH

// source count and index width
`define TLVI_NSRC 22
`define TLVI_IDX_W 5

// register addresses on the special register port
`define TLVI_ADDR_IE 8'hA8
`define TLVI_ADDR_IP 8'hB0
`define TLVI_ADDR_EIE_A 8'hB1
`define TLVI_ADDR_EIE_B 8'hB2
`define TLVI_ADDR_EIP_A 8'hB3
`define TLVI_ADDR_EIP_B 8'hB4
`define TLVI_ADDR_STAT 8'hB5
`define TLVI_ADDR_WIN 8'hB6
`define TLVI_ADDR_REQ0 8'hB7
`define TLVI_ADDR_REQ1 8'hB8
`define TLVI_ADDR_REQ2 8'hB9

// field positions
`define TLVI_GATE_BIT 7
`define TLVI_SPARE_BIT 6
`define TLVI_BASE_SRC_W 6
`define TLVI_STAT_ACT_LO 0
`define TLVI_STAT_ACT_HI 1
`define TLVI_STAT_HOLD 2
`define TLVI_STAT_CALL 3
`define TLVI_WIN_VALID 7
`define TLVI_WIN_HI 6

// reset values
`define TLVI_RST_IE 8'h00
`define TLVI_RST_IP 8'hC0
`define TLVI_RST_EXT 8'h00
`define TLVI_IP_RSVD 2'b11

// vector table
`define TLVI_VEC_BASE 16'h0003
`define TLVI_VEC_SHIFT 3

// timing in system clocks
`define TLVI_DETECT_CLK 1
`define TLVI_CALL_CLK 4
`define TLVI_CNT_W 3

`endif

//--- verilog/tlvi_arb.v
`timescale 1ns/100ps
`include "tlvi_consts.vh"

// two-pass fixed-order picker: high level first, then low
module tlvi_arb #(
    parameter N = `TLVI_NSRC,
    parameter IW = `TLVI_IDX_W
) (
    input wire [N-1:0] req_i,
    input wire [N-1:0] lvl_i,
    output reg valid_o,
    output reg hi_o,
    output reg [IW-1:0] idx_o
);

    integer i;

    always @* begin
        valid_o = 1'b0;
        hi_o = 1'b0;
        idx_o = {IW{1'b0}};
        // scanning downward lets the lowest order number win
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req_i[i] && lvl_i[i]) begin
                valid_o = 1'b1;
                hi_o = 1'b1;
                idx_o = i[IW-1:0];
            end
        end
        if (!valid_o) begin
            for (i = N - 1; i >= 0; i = i - 1) begin
                if (req_i[i]) begin
                    valid_o = 1'b1;
                    idx_o = i[IW-1:0];
                end
            end
        end
    end

endmodule // tlvi_arb

//--- verif/tlvi_irq_unit_assertions.sv
`timescale 1ns/100ps
module tlvi_irq_unit_assertions #(
    parameter NSRC = 22
) (
    input wire SYS_CLK_I,
    input wire RESETN_I,
    input wire [NSRC-1:0] SRC_PEND_I,
    input wire INSTR_END_I,
    input wire IRQ_RETURN_INSTR_END_I,
    input wire CALL_O,
    input wire [15:0] CALL_VEC_O,
    input wire [NSRC-1:0] SRC_ACK_O,
    input wire ACT_LO_O,
    input wire ACT_HI_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESETN_I);
    a_call_four_cycles: assert property ($rose(CALL_O) |-> CALL_O [*4] ##1 !CALL_O)
        else $error("call length wrong");
    a_vector_of_ack: assert property ($rose(CALL_O) |->
        CALL_VEC_O[2:0] == 3'b011 && SRC_ACK_O[(CALL_VEC_O - 16'h0003) >> 3])
        else $error("vector does not match source");
    a_ack_one_pulse: assert property (|SRC_ACK_O |-> $rose(CALL_O) && $onehot(SRC_ACK_O))
        else $error("ack not one-hot at call start");
    a_call_on_instr: assert property ($rose(CALL_O) |->
        $past(INSTR_END_I) && !$past(IRQ_RETURN_INSTR_END_I))
        else $error("call not after instruction end");
    a_ack_was_pending: assert property ($rose(CALL_O) |->
        |(SRC_ACK_O & ($past(SRC_PEND_I, 2) | $past(SRC_PEND_I, 3))))
        else $error("call for source not pending");
    a_high_not_preempt: assert property ($rose(CALL_O) |-> !ACT_HI_O)
        else $error("high routine preempted");
    a_low_to_high: assert property ($rose(CALL_O) && ACT_LO_O |-> ##1 ACT_HI_O)
        else $error("low routine nested by low call");
    a_level_set: assert property ($rose(CALL_O) |-> ##1 (ACT_LO_O || ACT_HI_O))
        else $error("active level not set at entry");
endmodule // tlvi_irq_unit_assertions

bind tlvi_irq_unit tlvi_irq_unit_assertions #(.NSRC(NSRC)) chk (
    .SYS_CLK_I(SYS_CLK_I),
    .RESETN_I(RESETN_I),
    .SRC_PEND_I(SRC_PEND_I),
    .INSTR_END_I(INSTR_END_I),
    .IRQ_RETURN_INSTR_END_I(IRQ_RETURN_INSTR_END_I),
    .CALL_O(CALL_O),
    .CALL_VEC_O(CALL_VEC_O),
    .SRC_ACK_O(SRC_ACK_O),
    .ACT_LO_O(ACT_LO_O),
    .ACT_HI_O(ACT_HI_O)
);

//--- verif/tlvi_core_model.sv
`timescale 1ns/100ps
// core side: ends an instruction every gap cycles, return on request
module tlvi_core_model (
    input wire clk_i,
    input wire rstn_i,
    input wire busy_i,
    input wire [3:0] gap_i,
    input wire ret_i,
    output reg ie_o,
    output reg re_o
);
    reg [3:0] cnt;
    reg ret_pend;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 4'h0;
            ret_pend <= 1'b0;
            ie_o <= 1'b0;
            re_o <= 1'b0;
        end else begin
            ie_o <= 1'b0;
            re_o <= 1'b0;
            if (ret_i)
                ret_pend <= 1'b1;
            if (busy_i) begin
                cnt <= 4'h0;
            end else if (cnt + 4'h1 >= gap_i) begin
                cnt <= 4'h0;
                re_o <= ret_pend;
                ie_o <= !ret_pend;
                if (ret_pend)
                    ret_pend <= 1'b0;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule // tlvi_core_model

//--- verif/tlvi_irq_unit_tb.sv
`timescale 1ns/100ps
module tlvi_irq_unit_tb;
    reg clk = 0;
    reg rstn = 0;
    reg [7:0] addr = 0;
    reg wr = 0;
    reg [7:0] wdata = 0;
    reg rd = 0;
    reg [21:0] pend = 0;
    reg [3:0] gap = 1;
    reg ret_req = 0;
    wire [7:0] rdata;
    wire ie, re, call, alo, ahi;
    wire [15:0] vec;
    wire [21:0] ack;
    integer num_errors = 0;
    integer check_count = 0;
    integer i, n;
    tlvi_irq_unit dut (
        .SYS_CLK_I(clk),
        .RESETN_I(rstn),
        .SFR_ADDR_I(addr),
        .SFR_WR_I(wr),
        .SFR_WDATA_I(wdata),
        .SFR_RD_I(rd),
        .SFR_RDATA_O(rdata),
        .SRC_PEND_I(pend),
        .INSTR_END_I(ie),
        .IRQ_RETURN_INSTR_END_I(re),
        .CALL_O(call),
        .CALL_VEC_O(vec),
        .SRC_ACK_O(ack),
        .ACT_LO_O(alo),
        .ACT_HI_O(ahi)
    );
    tlvi_core_model core (
        .clk_i(clk),
        .rstn_i(rstn),
        .busy_i(call),
        .gap_i(gap),
        .ret_i(ret_req),
        .ie_o(ie),
        .re_o(re)
    );
    initial forever #2 clk = ~clk;
    task conclude;
        begin
            $display("checks %0d errors %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer k);
        begin
            repeat (k) @(posedge clk);
            #1;
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            addr = a;
            wdata = d;
            wr = 1;
            tick(1);
            wr = 0;
            tick(1);
        end
    endtask
    task rd_chk(input [7:0] a, input [7:0] e);
        begin
            addr = a;
            rd = 1;
            tick(1);
            rd = 0;
            chk(rdata, e);
            tick(1);
        end
    endtask
    task no_call(input integer k);
        begin
            repeat (k) begin
                tick(1);
                chk(call, 0);
            end
        end
    endtask
    task wait_call(input integer o);
        begin
            n = 0;
            while (call !== 1'b1 && n < 40) begin
                tick(1);
                n = n + 1;
            end
            if (n == 40) begin chk(0, 1); conclude; end
            chk(vec, 16'h0003 + o * 8);
            chk(ack, 22'h1 << o);
            tick(5);
        end
    endtask
    task ret;
        begin
            ret_req = 1;
            tick(1);
            ret_req = 0;
            n = 0;
            while (re !== 1'b1 && n < 20) begin
                tick(1);
                n = n + 1;
            end
            if (n == 20) begin chk(0, 1); conclude; end
        end
    endtask
    task t_regs;
        begin
            rd_chk(8'hA8, 8'h00);
            rd_chk(8'hB0, 8'hC0);
            rd_chk(8'hB4, 8'h00);
            rd_chk(8'hC7, 8'h00);
            wr_reg(8'hB0, 8'h15);
            rd_chk(8'hB0, 8'hD5);
            wr_reg(8'hB3, 8'hA5);
            rd_chk(8'hB3, 8'hA5);
            wr_reg(8'hB0, 8'h00);
            wr_reg(8'hB3, 8'h00);
            $display("t_regs done");
        end
    endtask
    task t_gate;
        begin
            wr_reg(8'hA8, 8'h01);
            pend = 22'h1;
            no_call(12);
            wr_reg(8'hA8, 8'h80);
            no_call(12);
            wr_reg(8'hA8, 8'h81);
            wait_call(0);
            chk(alo, 1);
            rd_chk(8'hB7, 8'h01);
            rd_chk(8'hB5, 8'h01);
            rd_chk(8'hB6, 8'h00);
            pend = 0;
            ret;
            $display("t_gate done");
        end
    endtask
    task t_latency;
        begin
            wr_reg(8'hA8, 8'h82);
            pend = 22'h2;
            tick(2);
            chk(call, 1);
            tick(3);
            chk(call, 1);
            tick(1);
            chk(call, 0);
            gap = 3;
            ret;
            n = 0;
            while (ie !== 1'b1 && n < 10) begin
                chk(call, 0);
                tick(1);
                n = n + 1;
            end
            tick(1);
            chk(call, 1);
            pend = 0;
            tick(5);
            ret;
            gap = 1;
            $display("t_latency done");
        end
    endtask
    task t_vec;
        begin
            wr_reg(8'hA8, 8'h80);
            wr_reg(8'hB1, 8'h80);
            wr_reg(8'hB2, 8'h92);
            for (i = 0; i < 4; i = i + 1) begin
                n = (i == 0) ? 13 : (i == 1) ? 15 : (i == 2) ? 18 : 21;
                pend = 22'h1 << n;
                wait_call(n);
                pend = 0;
                ret;
            end
            $display("t_vec done");
        end
    endtask
    task t_prio;
        begin
            wr_reg(8'hA8, 8'hA0);
            wr_reg(8'hB1, 8'h28);
            wr_reg(8'hB2, 8'h10);
            wr_reg(8'hB4, 8'h10);
            pend = 22'h04_0020;
            wait_call(18);
            chk(ahi, 1);
            no_call(12);
            pend = 22'h20;
            ret;
            wait_call(5);
            pend = 22'h0A20;
            no_call(12);
            pend = 22'h0A00;
            ret;
            wait_call(9);
            pend = 22'h04_0800;
            wait_call(18);
            pend = 22'h0800;
            ret;
            ret;
            wait_call(11);
            pend = 0;
            ret;
            $display("t_prio done");
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rstn = 1;
        tick(1);
        t_regs;
        t_gate;
        t_latency;
        t_vec;
        t_prio;
        conclude;
    end
endmodule // tlvi_irq_unit_tb
